// ===== src/tcp_port.v
// typewriter character port: input capture, output fifo and handshake
`timescale 1ns/10ps
`default_nettype none
`include "tcp_defs.vh"

// ==========================================================
// fifo
module tcp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             rst,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;

  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage has no reset; only the count_reg words from rd_ptr_reg onward are ever read out
  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop) begin
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // tcp_fifo

// ==========================================================
// two-flop synchroniser
// every bit is synchronised on its own, so a word caught while it
// changes may land with mixed bits; the input capture waits for the
// strobe edge, which comes through the same depth after the word settled
module tcp_sync2 #(
  parameter             WIDTH = 1,
  parameter [WIDTH-1:0] INIT  = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             rst,
  // asynchronous side
  input  wire [WIDTH-1:0] async_in,
  // clock domain side
  output wire [WIDTH-1:0] sync_out
);
  genvar i;

  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg s1_reg;
      reg s2_reg;

      always @(posedge ref_clk) begin
        if (rst) begin
          s1_reg <= INIT[i];
          s2_reg <= INIT[i];
        end else begin
          s1_reg <= async_in[i];
          s2_reg <= s1_reg;
        end
      end

      // only the second flop leaves the synchroniser
      assign sync_out[i] = s2_reg;
    end
  endgenerate
endmodule // tcp_sync2

// ==========================================================
// top
module tcp_port (
  // clock and reset
  input  wire                   ref_clk,
  input  wire                   rst,
  // input connector from typewriter
  input  wire [`TCP_DATA_W-1:0] in_char_pins,
  input  wire                   in_strobe_pin,
  // captured input to the computer
  output reg  [`TCP_DATA_W-1:0] rx_data,
  output reg                    rx_valid,
  output wire                   input_ready_line,
  // characters from the computer
  input  wire                   tx_valid,
  output wire                   tx_ready,
  input  wire [`TCP_DATA_W-1:0] tx_data,
  // output connector to typewriter
  output reg  [`TCP_DATA_W-1:0] out_char_pins,
  output reg                    output_strobe_line,
  input  wire                   tw_ready_pin,
  // program control
  input  wire                   receive_cmd,
  output reg                    program_output_lines
);
  // ========================================================
  // synchronisers
  // the ready pin idles high, so its flops reset high and no false
  // acknowledgement is seen while the port comes out of reset
  wire [`TCP_DATA_W-1:0] din_sync;
  wire                   stb_sync;
  wire                   rdy_sync;
  reg                    stb_d_reg;

  tcp_sync2 #(
    .WIDTH (`TCP_DATA_W),
    .INIT  ({`TCP_DATA_W{1'b0}})
  ) u_din_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (in_char_pins),
    .sync_out (din_sync)
  );

  tcp_sync2 #(
    .WIDTH (1),
    .INIT  (1'b0)
  ) u_stb_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (in_strobe_pin),
    .sync_out (stb_sync)
  );

  tcp_sync2 #(
    .WIDTH (1),
    .INIT  (1'b1)
  ) u_rdy_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (tw_ready_pin),
    .sync_out (rdy_sync)
  );

  // strobe history for the edge detector; idle level is low
  always @(posedge ref_clk) begin
    if (rst) begin
      stb_d_reg <= 1'b0;
    end else begin
      stb_d_reg <= stb_sync;
    end
  end

  // ========================================================
  // input pulse stretcher
  // a strobe too short for two flops may be missed; the typewriter's
  // strobe is assumed to span at least two cycles
  // the cycle count is worked out as an integer; only its low bits load
  localparam [31:0] STRETCH_LOAD = `TCP_STRETCH_CYC;

  reg [`TCP_CNT_W-1:0] input_pulse_stretcher_reg;
  wire                 stb_rise;

  assign stb_rise         = stb_sync & ~stb_d_reg;
  assign input_ready_line = (input_pulse_stretcher_reg != {`TCP_CNT_W{1'b0}});

  always @(posedge ref_clk) begin
    if (rst) begin
      input_pulse_stretcher_reg <= {`TCP_CNT_W{1'b0}};
    end else if (stb_rise) begin
      input_pulse_stretcher_reg <= STRETCH_LOAD[`TCP_CNT_W-1:0];
    end else if (input_ready_line) begin
      input_pulse_stretcher_reg <= input_pulse_stretcher_reg - 4'h1;
    end
  end

  // capture once, on the first cycle of the widened ready
  always @(posedge ref_clk) begin
    if (rst) begin
      rx_data  <= {`TCP_DATA_W{1'b0}};
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= stb_rise & ~program_output_lines;
      if (stb_rise) begin
        rx_data <= din_sync;
      end
    end
  end

  // ========================================================
  // mode line
  always @(posedge ref_clk) begin
    if (rst) begin
      program_output_lines <= 1'b0;
    end else begin
      program_output_lines <= receive_cmd;
    end
  end

  // ========================================================
  // output fifo and handshake
  localparam [1:0] ST_IDLE    = 2'h0;
  localparam [1:0] ST_STROBE  = 2'h1;
  localparam [1:0] ST_RELEASE = 2'h2;

  wire                   fifo_valid;
  wire [`TCP_DATA_W-1:0] fifo_data;
  reg                    fifo_pop;
  reg  [1:0]             state_reg;
  reg  [1:0]             state_next;
  wire                   second_pulse_stretcher;

  // ready reply is active low at the pin
  assign second_pulse_stretcher = ~rdy_sync;

  tcp_fifo #(
    .WIDTH (`TCP_DATA_W),
    .DEPTH (`TCP_FIFO_DEPTH),
    .AW    (`TCP_FIFO_AW)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  always @* begin
    state_next = state_reg;
    fifo_pop   = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (fifo_valid & program_output_lines & ~second_pulse_stretcher) begin
          fifo_pop   = 1'b1;
          state_next = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (second_pulse_stretcher) begin
          state_next = ST_RELEASE;
        end
      end
      // waiting for the reply to clear keeps one long acknowledgement
      // from retiring the next character as well
      ST_RELEASE: begin
        if (~second_pulse_stretcher) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      state_reg          <= ST_IDLE;
      out_char_pins      <= {`TCP_DATA_W{1'b0}};
      output_strobe_line <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (fifo_pop) begin
        out_char_pins <= fifo_data;
      end
      output_strobe_line <= (state_next == ST_STROBE);
    end
  end
endmodule // tcp_port
`default_nettype wire

// ===== pkg/tcp_defs.vh
// constants for the typewriter character port
`ifndef TCP_DEFS_VH
`define TCP_DEFS_VH
// ==========================================================
// widths and timing
`define TCP_DATA_W       8
`define TCP_FIFO_DEPTH   8
`define TCP_FIFO_AW      3
// stretched strobe width in ns and in cycles (8 ns period)
`define TCP_STRETCH_NS   64
`define TCP_CLK_NS       8
`define TCP_STRETCH_CYC  ((`TCP_STRETCH_NS + `TCP_CLK_NS - 1) / `TCP_CLK_NS)
`define TCP_CNT_W        4
`endif

// ===== bench/tcp_chk.sv
// assertion checker for the typewriter character port
`timescale 1ns/10ps
`default_nettype none
module tcp_chk (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // input side
  input wire logic [7:0] in_char_pins,
  input wire logic [7:0] rx_data,
  input wire logic       rx_valid,
  input wire logic       input_ready_line,
  // output side
  input wire logic [7:0] out_char_pins,
  input wire logic       output_strobe_line,
  input wire logic       tw_ready_pin,
  input wire logic       program_output_lines
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_ack;
    output_strobe_line && $fell(tw_ready_pin);
  endsequence
  sequence s_busy;
    !tw_ready_pin [*4];
  endsequence
  a_ready_width: assert property ($rose(input_ready_line) |->
    input_ready_line [*8] ##1 !input_ready_line) else $error("ready width");
  a_rx_qual: assert property (rx_valid |->
    $rose(input_ready_line)) else $error("rx without ready");
  a_rx_data: assert property ($rose(input_ready_line) |->
    rx_data == $past(in_char_pins, 2)) else $error("rx data");
  a_rx_mode: assert property (program_output_lines |=>
    !rx_valid) else $error("rx in receive mode");
  a_tx_mode: assert property ($rose(output_strobe_line) |->
    $past(program_output_lines)) else $error("strobe in send mode");
  a_data_hold: assert property (output_strobe_line &&
    $past(output_strobe_line) |-> $stable(out_char_pins))
    else $error("data moved");
  a_ack_drop: assert property (s_ack |->
    ##[1:4] !output_strobe_line) else $error("strobe kept");
  a_drop_cause: assert property ($fell(output_strobe_line) |->
    !$past(tw_ready_pin, 2)) else $error("early drop");
  a_busy_wait: assert property (s_busy |=>
    !$rose(output_strobe_line)) else $error("strobe while busy");
endmodule // tcp_chk
bind tcp_port tcp_chk chk (.ref_clk(ref_clk), .rst(rst),
  .in_char_pins(in_char_pins), .rx_data(rx_data), .rx_valid(rx_valid),
  .input_ready_line(input_ready_line), .out_char_pins(out_char_pins),
  .output_strobe_line(output_strobe_line), .tw_ready_pin(tw_ready_pin),
  .program_output_lines(program_output_lines));
`default_nettype wire

// ===== bench/tcp_tw_model.sv
// typewriter model receiving on the output connector
`timescale 1ns/10ps
`default_nettype none
module tcp_tw_model (
  // clock
  input wire logic       ref_clk,
  // output connector
  input wire logic [7:0] out_char_pins,
  input wire logic       output_strobe_line,
  output var logic       tw_ready_pin,
  // reply delay in cycles
  input wire logic [3:0] delay
);
  logic [7:0] q[$];
  // low ready is the reply; held until delay cycles after the strobe drops
  initial begin
    tw_ready_pin = 1'b1;
    forever begin
      @(posedge ref_clk);
      if (output_strobe_line) begin
        q.push_back(out_char_pins);
        repeat (delay) @(posedge ref_clk);
        tw_ready_pin <= 1'b0;
        while (output_strobe_line) @(posedge ref_clk);
        repeat (delay) @(posedge ref_clk);
        tw_ready_pin <= 1'b1;
      end
    end
  end
endmodule // tcp_tw_model
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the typewriter character port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic ref_clk = 0, rst = 1, in_strobe_pin = 0, tx_valid = 0;
  logic receive_cmd = 0, full_seen = 0, rx_valid, input_ready_line;
  logic [7:0] in_char_pins = 0, tx_data = 0, rx_data, out_char_pins;
  logic tx_ready, output_strobe_line, tw_ready_pin, program_output_lines;
  logic [3:0] delay = 0;
  logic [7:0] sq[$];
  int fail_count = 0, n_checks = 0, n_rx = 0;
  tcp_port uut (.ref_clk(ref_clk), .rst(rst), .in_char_pins(in_char_pins),
    .in_strobe_pin(in_strobe_pin), .rx_data(rx_data), .rx_valid(rx_valid),
    .input_ready_line(input_ready_line), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .out_char_pins(out_char_pins),
    .output_strobe_line(output_strobe_line), .tw_ready_pin(tw_ready_pin),
    .receive_cmd(receive_cmd), .program_output_lines(program_output_lines));
  tcp_tw_model tw (.ref_clk(ref_clk), .out_char_pins(out_char_pins),
    .output_strobe_line(output_strobe_line), .tw_ready_pin(tw_ready_pin),
    .delay(delay));
  initial forever #4 ref_clk = ~ref_clk;
  always @(negedge ref_clk) begin
    if (tx_ready === 1'b0) full_seen = 1;
    if (rx_valid === 1'b1) n_rx++;
  end
  function automatic [7:0] exp_rx(input logic mode);
    return mode ? 8'h00 : 8'h01;
  endfunction
  task chk(input [7:0] g, input [7:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task send_in(input [7:0] c);
    int k;
    k = n_rx;
    in_char_pins <= c;
    in_strobe_pin <= 1;
    repeat (3) @(posedge ref_clk);
    in_strobe_pin <= 0;
    in_char_pins <= ~c;
    repeat (12) @(posedge ref_clk);
    chk(rx_data, c);
    chk(8'(n_rx - k), exp_rx(receive_cmd));
  endtask
  // tx_valid stays up across the queue; drops once it is empty
  task push_drain(input int wait_n);
    foreach (sq[i]) begin
      tx_data <= sq[i];
      tx_valid <= 1;
      @(negedge ref_clk);
      while (!tx_ready) @(negedge ref_clk);
      @(posedge ref_clk);
    end
    tx_valid <= 0;
    repeat (wait_n) @(posedge ref_clk);
    if (!receive_cmd) chk(8'(tw.q.size()), 8'h00);
    receive_cmd <= 1;
    while (tw.q.size() < sq.size()) @(posedge ref_clk);
    foreach (sq[i]) chk(tw.q[i], sq[i]);
    repeat (60) @(posedge ref_clk);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(29));
    repeat (4) @(posedge ref_clk);
    rst <= 0;
    repeat (3) @(posedge ref_clk);
    send_in(8'h00);
    send_in(8'hff);
    repeat (4) send_in(8'($urandom));
    receive_cmd <= 1;
    @(posedge ref_clk);
    send_in(8'ha5);
    delay <= 4'hf;
    repeat (12) sq.push_back(8'($urandom));
    push_drain(0);
    chk(full_seen, 1'b1);
    receive_cmd <= 0;
    delay <= 4'h0;
    sq = '{8'h00, 8'hff, 8'h3c};
    tw.q.delete();
    send_in(8'h5a);
    push_drain(40);
    report_and_stop;
  end
  initial begin
    repeat (6000) @(posedge ref_clk);
    fail_count++;
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
